//--- design/scp_port.sv
// serial configuration port with three register pages and bring-up calibration timer
//
// Behaviour
// - the port runs 3-wire on the shared data pin or 4-wire with a separate output pin.
// - instruction bit 7 at 0 asks for a write and at 1 asks for a read.
// - the two count bits give one to four data bytes after the instruction byte.
// - the five low instruction bits address the first register of the transfer.
// - each further data byte goes to the next lower register address.
// - registers sit in three pages of 32 and the last one of each holds 00h, 01h or 0Ah.
// - writing both clock-domain reset bits to 0 while either is 1 starts the automatic calibration.
// - the device reports ready 30 us after the calibration starts.
`include "scp_defines.svh"

module scp_port #(
  parameter int CAL_CYCLES = `SCP_CAL_CYCLES
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // serial pins
  input  wire logic sclk,
  input  wire logic serial_select_low,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      sdo_out,
  output logic      sdo_oe,
  // configuration and bring-up pins
  input  wire logic hw_reset_low,
  input  wire logic three_wire,
  // status
  output logic      conv_clock_domain_reset,
  output logic      link_clock_domain_reset,
  output logic      cal_busy,
  output logic      device_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------------
  scp_pkg::scp_pins_t pins_raw;
  scp_pkg::scp_pins_t pins_s;
  logic               sclk_p_q;

  assign pins_raw = '{sclk: sclk, serial_select_low: serial_select_low, sdio: sdio_in,
                      hw_reset_low: hw_reset_low, three_wire: three_wire};

  // select idles high so a reset never fakes a frame
  scp_sync #(
    .W       (5),
    .RST_VAL (5'h08)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (pins_raw),
    .dout (pins_s)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_p_q <= 1'b0;
    end else begin
      sclk_p_q <= pins_s.sclk;
    end
  end

  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic hw_rst;

  assign cs_active = ~pins_s.serial_select_low;
  assign sclk_rise = pins_s.sclk & ~sclk_p_q;
  assign sclk_fall = ~pins_s.sclk & sclk_p_q;
  assign hw_rst    = ~pins_s.hw_reset_low;

  // ----------------------------------------------------------------------------
  // register pages
  // ----------------------------------------------------------------------------
  logic [7:0] mem_q [0:`SCP_NUM_PAGES*`SCP_PAGE_REGS-1];
  logic [1:0] page_q;
  logic [1:0] page_d;
  logic       wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_value;
  logic [6:0] wr_idx;
  logic [6:0] rd_idx;

  assign wr_idx = {page_q, wr_addr};
  assign rd_idx = {page_q, rd_addr};

  always_comb begin
    if (rd_addr == `SCP_PAGE_REG_ADDR) begin
      case (page_q)
        2'd1:    rd_value = `SCP_PAGE_CODE_1;
        2'd2:    rd_value = `SCP_PAGE_CODE_2;
        default: rd_value = `SCP_PAGE_CODE_0;
      endcase
    end else begin
      rd_value = mem_q[rd_idx];
    end
  end

  // the page register itself lives in page_q; its array slots stay unused
  always_comb begin
    page_d = page_q;
    if (hw_rst) begin
      page_d = 2'd0;
    end else if (wr_en && wr_addr == `SCP_PAGE_REG_ADDR) begin
      if (wr_data == `SCP_PAGE_CODE_0) begin
        page_d = 2'd0;
      end else if (wr_data == `SCP_PAGE_CODE_1) begin
        page_d = 2'd1;
      end else if (wr_data == `SCP_PAGE_CODE_2) begin
        page_d = 2'd2;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_q <= 2'd0;
      for (int i = 0; i < `SCP_NUM_PAGES*`SCP_PAGE_REGS; i++) begin
        mem_q[i] <= (i == 0) ? `SCP_MAIN_CTRL_RESET : `SCP_REG_RESET;
      end
    end else begin
      page_q <= page_d;
      if (hw_rst) begin
        for (int i = 0; i < `SCP_NUM_PAGES*`SCP_PAGE_REGS; i++) begin
          mem_q[i] <= (i == 0) ? `SCP_MAIN_CTRL_RESET : `SCP_REG_RESET;
        end
      end else if (wr_en && wr_addr != `SCP_PAGE_REG_ADDR) begin
        mem_q[wr_idx] <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------------------
  scp_pkg::scp_state_t state_q,   state_d;
  scp_pkg::scp_instr_t instr_q,   instr_d;
  logic [2:0]          bit_cnt_q, bit_cnt_d;
  logic [1:0]          byte_cnt_q, byte_cnt_d;
  logic [4:0]          addr_q,    addr_d;
  logic [7:0]          shin_q,    shin_d;
  logic [7:0]          shout_q,   shout_d;
  logic                out_bit_q, out_bit_d;
  logic                drive_q,   drive_d;
  logic [7:0]          byte_in;
  logic                byte_end;

  assign byte_in  = {shin_q[6:0], pins_s.sdio};
  assign byte_end = sclk_rise && (bit_cnt_q == 3'd7);
  // address whose value is preloaded for the next outgoing byte
  assign rd_addr  = (state_q == scp_pkg::ST_DATA) ? (addr_q - 5'h01) : byte_in[4:0];

  always_comb begin
    state_d    = state_q;
    instr_d    = instr_q;
    bit_cnt_d  = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    addr_d     = addr_q;
    shin_d     = shin_q;
    shout_d    = shout_q;
    out_bit_d  = out_bit_q;
    drive_d    = drive_q;
    wr_en      = 1'b0;
    wr_addr    = addr_q;
    wr_data    = byte_in;
    if (!cs_active || hw_rst) begin
      state_d   = scp_pkg::ST_IDLE;
      bit_cnt_d = 3'd0;
      drive_d   = 1'b0;
    end else begin
      if (sclk_rise) begin
        shin_d    = byte_in;
        bit_cnt_d = bit_cnt_q + 3'd1;
      end
      case (state_q)
        scp_pkg::ST_IDLE, scp_pkg::ST_INSTR: begin
          state_d = scp_pkg::ST_INSTR;
          if (byte_end) begin
            instr_d    = byte_in;
            addr_d     = byte_in[4:0];
            byte_cnt_d = byte_in[6:5];
            shout_d    = rd_value;
            state_d    = scp_pkg::ST_DATA;
          end
        end
        scp_pkg::ST_DATA: begin
          if (sclk_fall && instr_q.rd) begin
            out_bit_d = shout_q[7];
            shout_d   = {shout_q[6:0], 1'b0};
            drive_d   = 1'b1;
          end
          if (byte_end) begin
            wr_en   = ~instr_q.rd;
            addr_d  = addr_q - 5'h01;
            shout_d = rd_value;
            if (byte_cnt_q == 2'd0) begin
              state_d = scp_pkg::ST_DONE;
              drive_d = 1'b0;
            end else begin
              byte_cnt_d = byte_cnt_q - 2'd1;
            end
          end
        end
        default: begin
          // extra clocks after the last byte are ignored
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q    <= scp_pkg::ST_IDLE;
      instr_q    <= '0;
      bit_cnt_q  <= 3'd0;
      byte_cnt_q <= 2'd0;
      addr_q     <= 5'h00;
      shin_q     <= 8'h00;
      shout_q    <= 8'h00;
      out_bit_q  <= 1'b0;
      drive_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      instr_q    <= instr_d;
      bit_cnt_q  <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      addr_q     <= addr_d;
      shin_q     <= shin_d;
      shout_q    <= shout_d;
      out_bit_q  <= out_bit_d;
      drive_q    <= drive_d;
    end
  end

  // one pin pair only: shared pin in 3-wire, dedicated output in 4-wire
  assign sdio_out = out_bit_q;
  assign sdo_out  = out_bit_q;
  assign sdio_oe  = drive_q & pins_s.three_wire;
  assign sdo_oe   = drive_q & ~pins_s.three_wire;

  // ----------------------------------------------------------------------------
  // bring-up calibration timer
  // ----------------------------------------------------------------------------
  logic [15:0] cal_cnt_q, cal_cnt_d;
  logic        cal_busy_q, cal_busy_d;
  logic        ready_q,    ready_d;
  logic        main_wr;
  logic        cal_start;

  assign conv_clock_domain_reset = mem_q[`SCP_MAIN_CTRL_ADDR][`SCP_CONV_RST_BIT];
  assign link_clock_domain_reset = mem_q[`SCP_MAIN_CTRL_ADDR][`SCP_LINK_RST_BIT];
  assign main_wr   = wr_en && !hw_rst && page_q == 2'd0 && wr_addr == `SCP_MAIN_CTRL_ADDR;
  // only the release of the resets starts it, rewriting zeros does not restart
  assign cal_start = main_wr && !wr_data[`SCP_CONV_RST_BIT] && !wr_data[`SCP_LINK_RST_BIT]
                     && (conv_clock_domain_reset || link_clock_domain_reset);

  always_comb begin
    cal_cnt_d  = cal_cnt_q;
    cal_busy_d = cal_busy_q;
    ready_d    = ready_q;
    if (hw_rst || (main_wr && (wr_data[`SCP_CONV_RST_BIT] || wr_data[`SCP_LINK_RST_BIT]))) begin
      cal_busy_d = 1'b0;
      ready_d    = 1'b0;
      cal_cnt_d  = 16'h0000;
    end else if (cal_start) begin
      cal_busy_d = 1'b1;
      ready_d    = 1'b0;
      cal_cnt_d  = 16'h0000;
    end else if (cal_busy_q) begin
      if (cal_cnt_q == 16'(CAL_CYCLES - 1)) begin
        cal_busy_d = 1'b0;
        ready_d    = 1'b1;
      end else begin
        cal_cnt_d = cal_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_cnt_q  <= 16'h0000;
      cal_busy_q <= 1'b0;
      ready_q    <= 1'b0;
    end else begin
      cal_cnt_q  <= cal_cnt_d;
      cal_busy_q <= cal_busy_d;
      ready_q    <= ready_d;
    end
  end

  assign cal_busy     = cal_busy_q;
  assign device_ready = ready_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_instr_done;
    state_q == scp_pkg::ST_INSTR && byte_end && cs_active && !hw_rst;
  endsequence

  sequence s_last_byte;
    state_q == scp_pkg::ST_DATA && byte_end && byte_cnt_q == 2'd0 && cs_active && !hw_rst;
  endsequence

  a_pins_exclusive: assert property (!(sdio_oe && sdo_oe))
    else $error("both serial outputs enabled");
  a_oe_read_only: assert property (sdio_oe |-> instr_q.rd && state_q == scp_pkg::ST_DATA)
    else $error("shared pin driven outside read data");
  a_oe_frame_end: assert property (!cs_active |=> !sdio_oe && !sdo_oe)
    else $error("output still driven after select released");
  a_write_dir: assert property (wr_en |-> !instr_q.rd)
    else $error("register written during a read");
  a_first_addr: assert property (s_instr_done |=> addr_q == $past(byte_in[4:0])
                                 && byte_cnt_q == $past(byte_in[6:5]))
    else $error("first address or count not taken from instruction");
  a_addr_down: assert property ((wr_en && !hw_rst) |=> addr_q == $past(addr_q) - 5'h01)
    else $error("address did not step down");
  a_byte_limit: assert property (s_last_byte |=> state_q == scp_pkg::ST_DONE ##1
                                 (!wr_en throughout (state_q == scp_pkg::ST_DONE)[*2]))
    else $error("transfer ran past its byte count");
  a_page_legal: assert property (page_q != 2'd3)
    else $error("page selection left its three values");
  a_cal_start: assert property (cal_start |=> cal_busy && !device_ready)
    else $error("calibration did not start");
  a_ready_time: assert property ($rose(device_ready) |-> $past(cal_cnt_q)
                                 == 16'(CAL_CYCLES - 1))
    else $error("ready before the calibration time");

endmodule : scp_port

//--- design/scp_sync.sv
// two-stage synchroniser for a group of pin levels
module scp_sync #(
  parameter int                W       = 1,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // levels
  input  wire logic [W-1:0]    din,
  output logic      [W-1:0]    dout
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : scp_sync

//--- pkg/scp_defines.svh
// constants of the serial configuration port: addresses, field positions, resets, timing
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define SCP_PAGE_REG_ADDR    5'h1f
`define SCP_MAIN_CTRL_ADDR   5'h00
`define SCP_CONV_RST_BIT     0
`define SCP_LINK_RST_BIT     1
`define SCP_MAIN_CTRL_RESET  8'h03
`define SCP_REG_RESET        8'h00
`define SCP_PAGE_CODE_0      8'h00
`define SCP_PAGE_CODE_1      8'h01
`define SCP_PAGE_CODE_2      8'h0a
`define SCP_PAGE_REGS        32
`define SCP_NUM_PAGES        3

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SCP_MCLK_PERIOD_NS   4
`define SCP_CAL_TIME_NS      30000
`define SCP_CAL_CYCLES       ((`SCP_CAL_TIME_NS + `SCP_MCLK_PERIOD_NS - 1) / `SCP_MCLK_PERIOD_NS)

`endif

//--- pkg/scp_pkg.sv
// types of the serial configuration port
package scp_pkg;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // instruction byte, msb first on the wire
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       byte_count_high;
    logic       byte_count_low;
    logic [4:0] addr;
  } scp_instr_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA,
    ST_DONE
  } scp_state_t;

  // ----------------------------------------------------------------------------
  // synchronised pin levels
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic serial_select_low;
    logic sdio;
    logic hw_reset_low;
    logic three_wire;
  } scp_pins_t;

endpackage : scp_pkg

//--- tb/scp_host_model.sv
// host model: serial master that frames transfers on the configuration port
module scp_host_model (
  // bench clock, used only to pace the serial clock
  input  wire logic mclk,
  // mode
  input  wire logic three_wire,
  // serial pins
  output logic      sclk,
  output logic      serial_select_low,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  // high while read data may come back
  output logic      win
);
  timeunit 1ns;
  timeprecision 100ps;

  logic hbit;
  logic hoe;

  // a released pin shows the inverse of the last bit, so a stale level never passes
  assign sdio_in = sdio_oe ? sdio_out : (hoe ? hbit : ~hbit);

  initial begin
    sclk = 1'b0;
    serial_select_low = 1'b1;
    hbit = 1'b0;
    hoe = 1'b1;
    win = 1'b0;
  end

  // half period of 20 ns keeps the serial clock at 25 mhz
  task automatic half;
    repeat (5) @(posedge mclk);
    #1;
  endtask : half

  // ----------------------------------------------------------------------------
  // one framed transfer; data byte k travels in bits 8k+7..8k
  // ----------------------------------------------------------------------------
  task automatic xfer(input logic rd, input logic [1:0] cnt, input logic [4:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd_d);
    logic [7:0] ins;
    ins = {rd, cnt, addr};
    rd_d = '0;
    serial_select_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hbit = ins[i];
      half;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
    hoe = !(rd && three_wire);
    win = rd;
    for (int k = 0; k <= cnt; k++) begin
      for (int i = 7; i >= 0; i--) begin
        hbit = wd[8*k+i];
        half;
        sclk = 1'b1;
        if (three_wire) begin
          rd_d[8*k+i] = sdio_oe ? sdio_in : 1'bx;
        end else begin
          rd_d[8*k+i] = sdo_oe ? sdo_out : 1'bx;
        end
        half;
        sclk = 1'b0;
      end
    end
    half;
    serial_select_low = 1'b1;
    hoe = 1'b1;
    half;
    win = 1'b0;
  endtask : xfer
endmodule : scp_host_model

//--- tb/tb.sv
// self-checking bench of the serial configuration port
`include "scp_defines.svh"
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CAL = 20;

  logic mclk, rst, sclk, ssl, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
  logic hw_reset_low, three_wire, conv_rst, link_rst, cal_busy, device_ready, win;
  int   fails = 0, checked = 0, bad = 0, cyc = 0, busy_n = 0;
  logic [31:0] d, msk;
  logic [7:0]  pg [3];

  always #2 mclk = ~mclk;

  scp_port #(.CAL_CYCLES(CAL)) DUT (
    .mclk(mclk), .rst(rst), .sclk(sclk), .serial_select_low(ssl), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .hw_reset_low(hw_reset_low), .three_wire(three_wire),
    .conv_clock_domain_reset(conv_rst), .link_clock_domain_reset(link_rst),
    .cal_busy(cal_busy), .device_ready(device_ready)
  );

  scp_host_model host (
    .mclk(mclk), .three_wire(three_wire), .sclk(sclk), .serial_select_low(ssl),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .win(win)
  );

  // ----------------------------------------------------------------------------
  // access tasks and verdict
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [1:0] c, input logic [31:0] v);
    logic [31:0] x;
    host.xfer(1'b0, c, a, v, x);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [1:0] c, input logic [31:0] e);
    logic [31:0] x;
    host.xfer(1'b1, c, a, 32'h0, x);
    `CHK(x, e)
  endtask : rdc

  task automatic results;
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // stray drive is counted, calibration length measured, hangs cut short
  always @(posedge mclk) begin
    if ((sdio_oe && !(three_wire && win)) || (sdo_oe && !(!three_wire && win))) begin
      bad <= bad + 1;
    end
    if (cal_busy) begin
      busy_n <= busy_n + 1;
    end else if (!device_ready) begin
      busy_n <= 0;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      results;
    end
  end

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    {mclk, hw_reset_low, three_wire, rst} = 4'b0101;
    pg = '{`SCP_PAGE_CODE_0, `SCP_PAGE_CODE_1, `SCP_PAGE_CODE_2};
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    `CHK({conv_rst, link_rst, cal_busy, device_ready}, 4'b1100)
    rdc(5'h00, 2'd1, {pg[0], `SCP_MAIN_CTRL_RESET});
    for (int m = 0; m < 2; m++) begin
      three_wire = m[0];
      repeat (8) @(posedge mclk);
      #1;
      for (int c = 0; c < 4; c++) begin
        d = 32'hc3a55a3c + m * 32'h01010101 + c * 32'h10101010;
        msk = 32'hffffffff >> (8 * (3 - c));
        wr(5'(8 + 5 * c), 2'(c), d);
        rdc(5'(8 + 5 * c), 2'(c), d & msk);
        rdc(5'(8 + 4 * c), 2'd0, {24'h0, d[8*c +: 8]});
      end
    end
    // a refused page code must leave the current page untouched
    wr(5'h06, 2'd0, 32'h5a);
    for (int p = 0; p < 3; p++) begin
      wr(5'h1f, 2'd0, {24'h0, pg[p]});
      wr(5'h1f, 2'd0, 32'h05);
      rdc(5'h1f, 2'd0, {24'h0, pg[p]});
      rdc(5'h06, 2'd0, (p == 0) ? 32'h5a : 32'h0);
    end
    wr(5'h1f, 2'd0, 32'h0);
    wr(5'h00, 2'd0, 32'h0);
    for (int i = 0; i < 100 && !device_ready; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK({conv_rst, link_rst, cal_busy, device_ready}, 4'b0001)
    `CHK(busy_n, CAL)
    wr(5'h00, 2'd0, 32'h01);
    repeat (4) @(posedge mclk);
    #1;
    `CHK({conv_rst, link_rst, cal_busy, device_ready}, 4'b1000)
    wr(5'h1f, 2'd0, 32'h01);
    hw_reset_low = 1'b0;
    repeat (8) @(posedge mclk);
    #1 hw_reset_low = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    rdc(5'h00, 2'd1, {pg[0], `SCP_MAIN_CTRL_RESET});
    `CHK(bad, 0)
    results;
  end
endmodule : tb
